// >>> rtl/root_port_command_gating_defines.svh
// Register map, field positions and reset values of the root port command gating block
`ifndef ROOT_PORT_COMMAND_GATING_DEFINES_SVH
`define ROOT_PORT_COMMAND_GATING_DEFINES_SVH

`define OFS_PORT_COMMAND   8'h04
`define OFS_IO_BASE        8'h18
`define OFS_IO_LIMIT       8'h1C
`define OFS_MEM_BASE       8'h20
`define OFS_MEM_LIMIT      8'h24
`define OFS_PF_BASE        8'h28
`define OFS_PF_LIMIT       8'h2C
`define OFS_PF_BASE_UP     8'h30
`define OFS_PF_LIMIT_UP    8'h34
`define OFS_BRIDGE_CTRL    8'h3C
`define OFS_PORT_STATUS    8'h40

`define CMD_IO_BIT         0
`define CMD_MEM_BIT        1
`define CMD_MASTER_BIT     2
`define CMD_SERR_BIT       8
`define BCTL_SERR_BIT      1
`define STS_CPU_RUN_BIT    0
`define STS_REJECT_BIT     1

`define CMD_RESET          16'h0000
`define CMD_WRITE_MASK     16'h0107
`define CMD_BRIDGE_MASK    16'h0003
`define WIN_BASE_RESET     32'hFFFFFFFF
`define WIN_LIMIT_RESET    32'h00000000

`endif

// >>> rtl/root_port_command_gating_pkg.sv
// Types shared by the root port command gating block
package root_port_command_gating_pkg;

  typedef enum logic [1:0] {KIND_MEM, KIND_IO, KIND_MSI, KIND_CFG} inbound_kind_type;
  typedef enum logic [1:0] {ERR_COR, ERR_NONFATAL, ERR_FATAL} err_class_type;

  typedef struct packed {
    logic             valid;
    inbound_kind_type kind;
  } inbound_req_type;

  typedef struct packed {
    logic valid;
    logic complete;
    logic unsupported;
  } inbound_verdict_type;

  typedef struct packed {
    logic        valid;
    logic        is_io;
    logic        self_hit;
    logic [63:0] addr;
  } primary_req_type;

  typedef struct packed {
    logic valid;
    logic claim;
  } primary_claim_type;

  typedef struct packed {
    logic          valid;
    err_class_type err_class;
  } err_msg_type;

  typedef struct packed {
    logic [15:0]         cmd;
    logic                bctl_serr;
    logic [31:0]         io_base;
    logic [31:0]         io_limit;
    logic [31:0]         mem_base;
    logic [31:0]         mem_limit;
    logic [31:0]         pf_base;
    logic [31:0]         pf_limit;
    logic [31:0]         pf_base_up;
    logic [31:0]         pf_limit_up;
    logic                run_s1;
    logic                run_s2;
    logic                reject_sticky;
    logic                ack;
    logic [31:0]         rdata;
    inbound_verdict_type verdict;
    primary_claim_type   claim;
    err_msg_type         fwd;
  } gating_state_type;

endpackage

// >>> rtl/root_port_command_gating.sv
// Command register gating of a root port seen as a virtual bridge
`timescale 1ns/1ps
`default_nettype none
`include "root_port_command_gating_defines.svh"

module root_port_command_gating #(
  parameter int unsigned PORT_INDEX = 1
) (
  input  wire logic                                      core_clk,
  input  wire logic                                      rst_n,
  input  wire logic [7:0]                                avs_address,
  input  wire logic                                      avs_read,
  input  wire logic                                      avs_write,
  input  wire logic [31:0]                               avs_writedata,
  input  wire logic [3:0]                                avs_byteenable,
  output logic [31:0]                                    avs_readdata,
  output logic                                           avs_waitrequest,
  input  wire logic                                      processor_reset_n,
  input  wire root_port_command_gating_pkg::inbound_req_type     inbound_req,
  output root_port_command_gating_pkg::inbound_verdict_type      inbound_verdict,
  input  wire root_port_command_gating_pkg::primary_req_type     primary_req,
  output root_port_command_gating_pkg::primary_claim_type        primary_claim,
  input  wire root_port_command_gating_pkg::err_msg_type         link_err,
  output root_port_command_gating_pkg::err_msg_type              err_forward
);
  import root_port_command_gating_pkg::*;

  localparam logic IS_BRIDGE = (PORT_INDEX != 0);

  gating_state_type st_ff;
  gating_state_type nxt_st;

  logic inbound_master_allow;
  logic memory_window_allow;
  logic io_window_allow;
  logic system_error_allow;
  logic bridge_error_forward_allow;
  logic mem_hit;
  logic io_hit;
  logic filtered_kind;
  logic bus_cmd_write;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic in_window(input logic [63:0] a, input logic [63:0] base, input logic [63:0] lim);
    return (a >= base) && (a <= lim);
  endfunction

  function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  assign inbound_master_allow       = st_ff.cmd[`CMD_MASTER_BIT];
  assign memory_window_allow        = IS_BRIDGE && st_ff.cmd[`CMD_MEM_BIT];
  assign io_window_allow            = IS_BRIDGE && st_ff.cmd[`CMD_IO_BIT];
  assign system_error_allow         = st_ff.cmd[`CMD_SERR_BIT];
  assign bridge_error_forward_allow = st_ff.bctl_serr;

  assign mem_hit = in_window(primary_req.addr, {32'h00000000, st_ff.mem_base}, {32'h00000000, st_ff.mem_limit})
                || in_window(primary_req.addr, {st_ff.pf_base_up, st_ff.pf_base}, {st_ff.pf_limit_up, st_ff.pf_limit});
  assign io_hit  = in_window(primary_req.addr, {32'h00000000, st_ff.io_base}, {32'h00000000, st_ff.io_limit});

  assign filtered_kind = (inbound_req.kind != KIND_CFG);
  assign bus_cmd_write = st_ff.ack && avs_write && (avs_address == `OFS_PORT_COMMAND);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] rd_val;
    logic [31:0] cmd_merged;
    rd_val = 32'h00000000;
    cmd_merged = merge_be({16'h0000, st_ff.cmd}, avs_writedata, avs_byteenable);
    nxt_st = st_ff;

    // One wait state: request seen, then answered on the next edge
    nxt_st.ack = (avs_read || avs_write) && !st_ff.ack;
    unique case (avs_address)
      `OFS_PORT_COMMAND: rd_val = {16'h0000, st_ff.cmd};
      `OFS_IO_BASE:      rd_val = st_ff.io_base;
      `OFS_IO_LIMIT:     rd_val = st_ff.io_limit;
      `OFS_MEM_BASE:     rd_val = st_ff.mem_base;
      `OFS_MEM_LIMIT:    rd_val = st_ff.mem_limit;
      `OFS_PF_BASE:      rd_val = st_ff.pf_base;
      `OFS_PF_LIMIT:     rd_val = st_ff.pf_limit;
      `OFS_PF_BASE_UP:   rd_val = st_ff.pf_base_up;
      `OFS_PF_LIMIT_UP:  rd_val = st_ff.pf_limit_up;
      `OFS_BRIDGE_CTRL:  rd_val[`BCTL_SERR_BIT] = st_ff.bctl_serr;
      `OFS_PORT_STATUS: begin
        rd_val[`STS_CPU_RUN_BIT] = st_ff.run_s2;
        rd_val[`STS_REJECT_BIT]  = st_ff.reject_sticky;
      end
      default:           rd_val = 32'h00000000;
    endcase
    if (avs_read && !st_ff.ack) begin
      nxt_st.rdata = rd_val;
    end

    if (st_ff.ack && avs_write) begin
      unique case (avs_address)
        `OFS_PORT_COMMAND: begin
          nxt_st.cmd = cmd_merged[15:0] & `CMD_WRITE_MASK;
          if (!IS_BRIDGE) begin
            nxt_st.cmd = nxt_st.cmd & ~`CMD_BRIDGE_MASK;
          end
        end
        `OFS_IO_BASE:     nxt_st.io_base     = merge_be(st_ff.io_base, avs_writedata, avs_byteenable);
        `OFS_IO_LIMIT:    nxt_st.io_limit    = merge_be(st_ff.io_limit, avs_writedata, avs_byteenable);
        `OFS_MEM_BASE:    nxt_st.mem_base    = merge_be(st_ff.mem_base, avs_writedata, avs_byteenable);
        `OFS_MEM_LIMIT:   nxt_st.mem_limit   = merge_be(st_ff.mem_limit, avs_writedata, avs_byteenable);
        `OFS_PF_BASE:     nxt_st.pf_base     = merge_be(st_ff.pf_base, avs_writedata, avs_byteenable);
        `OFS_PF_LIMIT:    nxt_st.pf_limit    = merge_be(st_ff.pf_limit, avs_writedata, avs_byteenable);
        `OFS_PF_BASE_UP:  nxt_st.pf_base_up  = merge_be(st_ff.pf_base_up, avs_writedata, avs_byteenable);
        `OFS_PF_LIMIT_UP: nxt_st.pf_limit_up = merge_be(st_ff.pf_limit_up, avs_writedata, avs_byteenable);
        `OFS_BRIDGE_CTRL: begin
          if (avs_byteenable[0]) begin
            nxt_st.bctl_serr = avs_writedata[`BCTL_SERR_BIT];
          end
        end
        `OFS_PORT_STATUS: begin
          if (avs_byteenable[0] && avs_writedata[`STS_REJECT_BIT]) begin
            nxt_st.reject_sticky = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Processor reset pin, two flops before use
    nxt_st.run_s1 = processor_reset_n;
    nxt_st.run_s2 = st_ff.run_s1;

    // Inbound filtering: configuration passes, the rest needs master enable
    nxt_st.verdict.valid       = inbound_req.valid;
    nxt_st.verdict.unsupported = inbound_req.valid && filtered_kind && !inbound_master_allow;
    nxt_st.verdict.complete    = inbound_req.valid && !(filtered_kind && !inbound_master_allow);
    if (inbound_req.valid && filtered_kind && !inbound_master_allow) begin
      nxt_st.reject_sticky = 1'b1;
    end

    // Positive decode on the primary side
    nxt_st.claim.valid = primary_req.valid;
    if (primary_req.is_io) begin
      nxt_st.claim.claim = primary_req.valid && io_window_allow && io_hit;
    end else begin
      nxt_st.claim.claim = primary_req.valid && memory_window_allow
                        && (mem_hit || primary_req.self_hit);
    end

    // Error message forwarding
    nxt_st.fwd.valid = link_err.valid && bridge_error_forward_allow
                    && ((link_err.err_class == ERR_COR) || system_error_allow);
    nxt_st.fwd.err_class = link_err.err_class;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff             <= '0;
      st_ff.cmd         <= `CMD_RESET;
      st_ff.io_base     <= `WIN_BASE_RESET;
      st_ff.io_limit    <= `WIN_LIMIT_RESET;
      st_ff.mem_base    <= `WIN_BASE_RESET;
      st_ff.mem_limit   <= `WIN_LIMIT_RESET;
      st_ff.pf_base     <= `WIN_BASE_RESET;
      st_ff.pf_limit    <= `WIN_LIMIT_RESET;
      st_ff.pf_base_up  <= `WIN_BASE_RESET;
      st_ff.pf_limit_up <= `WIN_LIMIT_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
  assign inbound_verdict = st_ff.verdict;
  assign primary_claim   = st_ff.claim;
  assign err_forward     = st_ff.fwd;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  property p_master_complete;
    inbound_req.valid && inbound_master_allow |=> inbound_verdict.complete && !inbound_verdict.unsupported;
  endproperty
  a_master_complete: assert property (p_master_complete) else $error("allowed inbound request not completed");

  property p_master_reject;
    inbound_req.valid && filtered_kind && !inbound_master_allow |=> inbound_verdict.unsupported ##1 st_ff.reject_sticky;
  endproperty
  a_master_reject: assert property (p_master_reject) else $error("blocked inbound request not unsupported");

  property p_cfg_pass;
    inbound_req.valid && (inbound_req.kind == KIND_CFG) |=> inbound_verdict.complete;
  endproperty
  a_cfg_pass: assert property (p_cfg_pass) else $error("configuration request filtered");

  property p_master_only_by_write;
    $rose(inbound_master_allow) |-> $past(bus_cmd_write);
  endproperty
  a_master_only_by_write: assert property (p_master_only_by_write) else $error("master enable set without write");

  property p_mem_claim;
    primary_req.valid && !primary_req.is_io && memory_window_allow && mem_hit |=> primary_claim.valid && primary_claim.claim;
  endproperty
  a_mem_claim: assert property (p_mem_claim) else $error("memory window access not claimed");

  property p_self_claim;
    primary_req.valid && !primary_req.is_io && primary_req.self_hit |=> primary_claim.claim == $past(memory_window_allow);
  endproperty
  a_self_claim: assert property (p_self_claim) else $error("bridge self access gating wrong");

  property p_mem_off;
    primary_req.valid && !primary_req.is_io && !memory_window_allow |=> !primary_claim.claim;
  endproperty
  a_mem_off: assert property (p_mem_off) else $error("memory claimed while disabled");

  property p_port0_hardwired;
    IS_BRIDGE || (st_ff.cmd & `CMD_BRIDGE_MASK) == 16'h0000;
  endproperty
  a_port0_hardwired: assert property (p_port0_hardwired) else $error("port zero window enable set");

  property p_io_claim;
    primary_req.valid && primary_req.is_io && io_window_allow && io_hit |=> primary_claim.claim;
  endproperty
  a_io_claim: assert property (p_io_claim) else $error("io window access not claimed");

  property p_io_off;
    primary_req.valid && primary_req.is_io && !(io_window_allow && io_hit) |=> !primary_claim.claim;
  endproperty
  a_io_off: assert property (p_io_off) else $error("io claimed while disabled or outside");

  property p_bridge_err_gate;
    !bridge_error_forward_allow |=> !err_forward.valid;
  endproperty
  a_bridge_err_gate: assert property (p_bridge_err_gate) else $error("error forwarded while bridge gate clear");

  property p_serr_gate;
    link_err.valid && bridge_error_forward_allow |=>
      err_forward.valid == (($past(link_err.err_class) == ERR_COR) || $past(system_error_allow));
  endproperty
  a_serr_gate: assert property (p_serr_gate) else $error("system error gating wrong");

  property p_bus_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered in one wait state");

  property p_verdict_follows;
    inbound_req.valid |=> inbound_verdict.valid;
  endproperty
  a_verdict_follows: assert property (p_verdict_follows) else $error("inbound request got no verdict");

  property p_verdict_idle;
    !inbound_req.valid |=> !inbound_verdict.valid && !inbound_verdict.unsupported;
  endproperty
  a_verdict_idle: assert property (p_verdict_idle) else $error("verdict without inbound request");

  property p_reject_sticky_set;
    $rose(st_ff.reject_sticky) |-> $past(inbound_req.valid && filtered_kind && !inbound_master_allow);
  endproperty
  a_reject_sticky_set: assert property (p_reject_sticky_set) else $error("reject flag set without refusal");

  property p_claim_follows;
    primary_req.valid |=> primary_claim.valid;
  endproperty
  a_claim_follows: assert property (p_claim_follows) else $error("primary access got no answer");

  property p_claim_idle;
    !primary_req.valid |=> !primary_claim.valid && !primary_claim.claim;
  endproperty
  a_claim_idle: assert property (p_claim_idle) else $error("claim without primary access");

  property p_mem_outside;
    primary_req.valid && !primary_req.is_io && !mem_hit && !primary_req.self_hit |=> !primary_claim.claim;
  endproperty
  a_mem_outside: assert property (p_mem_outside) else $error("memory claimed outside windows");

  property p_fwd_class;
    link_err.valid |=> err_forward.err_class == $past(link_err.err_class);
  endproperty
  a_fwd_class: assert property (p_fwd_class) else $error("forwarded error class differs");

  c_reject:   cover property (inbound_req.valid && filtered_kind && !inbound_master_allow);
  c_mem_hit:  cover property (primary_req.valid && !primary_req.is_io && memory_window_allow && mem_hit);
  c_io_hit:   cover property (primary_req.valid && primary_req.is_io && io_window_allow && io_hit);
  c_err_fwd:  cover property (err_forward.valid && err_forward.err_class == ERR_FATAL);
  c_self_hit: cover property (primary_req.valid && primary_req.self_hit && memory_window_allow);

endmodule
`default_nettype wire

// >>> sim/downstream_link_model.sv
// Far side model: link devices sending requests and error messages, host issuing primary accesses
`timescale 1ns/1ps
`default_nettype none
module downstream_link_model (
  input  wire logic                                         core_clk,
  input  wire logic                                         processor_reset_n,
  output var  root_port_command_gating_pkg::inbound_req_type     inbound_req,
  input  wire root_port_command_gating_pkg::inbound_verdict_type inbound_verdict,
  output var  root_port_command_gating_pkg::primary_req_type     primary_req,
  input  wire root_port_command_gating_pkg::primary_claim_type   primary_claim,
  output var  root_port_command_gating_pkg::err_msg_type         link_err,
  input  wire root_port_command_gating_pkg::err_msg_type         err_forward
);
  import root_port_command_gating_pkg::*;

  initial begin
    inbound_req = '0;
    primary_req = '0;
    link_err    = '0;
  end

  // Released fields show inverted values so stale data is never mistaken for a request
  task automatic send_inbound(input inbound_kind_type kind, output inbound_verdict_type got);
    while (processor_reset_n !== 1'b1) @(posedge core_clk);
    @(posedge core_clk);
    inbound_req <= '{valid: 1'b1, kind: kind};
    @(posedge core_clk);
    inbound_req <= '{valid: 1'b0, kind: inbound_kind_type'(~kind)};
    #1 got = inbound_verdict;
  endtask

  task automatic send_primary(input logic io, input logic self, input logic [63:0] addr,
                              output primary_claim_type got);
    @(posedge core_clk);
    primary_req <= '{valid: 1'b1, is_io: io, self_hit: self, addr: addr};
    @(posedge core_clk);
    primary_req <= '{valid: 1'b0, is_io: ~io, self_hit: ~self, addr: ~addr};
    #1 got = primary_claim;
  endtask

  task automatic send_err(input err_class_type cls, output err_msg_type got);
    @(posedge core_clk);
    link_err <= '{valid: 1'b1, err_class: cls};
    @(posedge core_clk);
    link_err <= '{valid: 1'b0, err_class: err_class_type'(~cls)};
    #1 got = err_forward;
  endtask
endmodule
`default_nettype wire

// >>> sim/tb_root_port_command_gating.sv
// Testbench of the root port command gating block
`timescale 1ns/1ps
`default_nettype none
`include "root_port_command_gating_defines.svh"
module tb_root_port_command_gating;
  import root_port_command_gating_pkg::*;
  logic                core_clk;
  logic                rst_n;
  logic [7:0]          avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [3:0]          avs_byteenable;
  logic [31:0]         avs_readdata;
  logic [31:0]         p0_readdata;
  logic                avs_waitrequest;
  logic                processor_reset_n;
  inbound_req_type     inbound_req;
  inbound_verdict_type inbound_verdict;
  primary_req_type     primary_req;
  primary_claim_type   primary_claim;
  err_msg_type         link_err;
  err_msg_type         err_forward;
  err_msg_type         e;
  int                  mismatches;
  int                  check_count;
  logic [31:0]         rd;
  logic [31:0]         rd_p0;
  logic [66:0]         probe_table [10];
  logic [39:0]         win_table [8];

  root_port_command_gating #(.PORT_INDEX(1)) root_port_command_gating_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .processor_reset_n(processor_reset_n),
    .inbound_req(inbound_req), .inbound_verdict(inbound_verdict), .primary_req(primary_req),
    .primary_claim(primary_claim), .link_err(link_err), .err_forward(err_forward));

  // Port zero copy shares the bus; only its read data is watched
  root_port_command_gating #(.PORT_INDEX(0)) root_port_command_gating_p0_i (
    .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(p0_readdata), .avs_waitrequest(), .processor_reset_n(processor_reset_n),
    .inbound_req(inbound_req), .inbound_verdict(), .primary_req(primary_req),
    .primary_claim(), .link_err(link_err), .err_forward());

  downstream_link_model downstream_link_model_i (
    .core_clk(core_clk), .processor_reset_n(processor_reset_n), .inbound_req(inbound_req),
    .inbound_verdict(inbound_verdict), .primary_req(primary_req), .primary_claim(primary_claim),
    .link_err(link_err), .err_forward(err_forward));

  always #2 core_clk = ~core_clk;

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus_access(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    avs_address   <= addr;
    avs_writedata <= data;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd    = avs_readdata;
    rd_p0 = p0_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic run_inbound(input logic allow);
    inbound_verdict_type v;
    for (int k = 0; k < 4; k++) begin
      downstream_link_model_i.send_inbound(inbound_kind_type'(k), v);
      check(32'(v), (allow || k == 3) ? 32'h6 : 32'h5);
    end
  endtask

  task automatic run_probes(input logic on);
    primary_claim_type c;
    for (int i = 0; i < 10; i++) begin
      downstream_link_model_i.send_primary(probe_table[i][66], probe_table[i][65], probe_table[i][64:1], c);
      check(32'(c), {30'h0, 1'b1, on & probe_table[i][0]});
    end
  endtask

  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    processor_reset_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    mismatches = 0;
    check_count = 0;
    // Fields: is_io, self_hit, address, claim expected while enabled
    probe_table = '{{2'b00, 64'h1000, 1'b1}, {2'b00, 64'h1FFF, 1'b1}, {2'b00, 64'h2000, 1'b0},
                    {2'b00, 64'h0FFF, 1'b0}, {2'b01, 64'h9000_0000, 1'b1}, {2'b00, 64'h1_0000_0800, 1'b1},
                    {2'b00, 64'h1_0000_1000, 1'b0}, {2'b10, 64'h100, 1'b1}, {2'b10, 64'h1FF, 1'b1},
                    {2'b10, 64'h200, 1'b0}};
    win_table = '{{`OFS_MEM_BASE, 32'h1000}, {`OFS_MEM_LIMIT, 32'h1FFF}, {`OFS_IO_BASE, 32'h100},
                  {`OFS_IO_LIMIT, 32'h1FF}, {`OFS_PF_BASE, 32'h0}, {`OFS_PF_LIMIT, 32'hFFF},
                  {`OFS_PF_BASE_UP, 32'h1}, {`OFS_PF_LIMIT_UP, 32'h1}};
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    bus_access(1'b0, `OFS_PORT_COMMAND, 32'h0);
    check(rd, 32'h0);
    processor_reset_n <= 1'b1;
    run_inbound(1'b0);
    bus_access(1'b0, `OFS_PORT_STATUS, 32'h0);
    check(rd, 32'h3);
    bus_access(1'b1, `OFS_PORT_STATUS, 32'h2);
    bus_access(1'b0, `OFS_PORT_STATUS, 32'h0);
    check(rd, 32'h1);
    bus_access(1'b1, `OFS_PORT_COMMAND, 32'hFFFF);
    bus_access(1'b0, `OFS_PORT_COMMAND, 32'h0);
    check(rd, 32'h0107);
    check(rd_p0, 32'h0104);
    avs_byteenable <= 4'h2;
    bus_access(1'b1, `OFS_PORT_COMMAND, 32'h0);
    avs_byteenable <= 4'hF;
    bus_access(1'b0, `OFS_PORT_COMMAND, 32'h0);
    check(rd, 32'h0007);
    check(rd_p0, 32'h0004);
    run_inbound(1'b1);
    bus_access(1'b1, 8'hFC, 32'hFFFF_FFFF);
    bus_access(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) bus_access(1'b1, win_table[i][39:32], win_table[i][31:0]);
    run_probes(1'b1);
    bus_access(1'b1, `OFS_PORT_COMMAND, 32'h0104);
    run_probes(1'b0);
    for (int i = 0; i < 3; i++) begin
      bus_access(1'b1, `OFS_PORT_COMMAND, (i == 1) ? 32'h0004 : 32'h0104);
      bus_access(1'b1, `OFS_BRIDGE_CTRL, (i == 0) ? 32'h0 : 32'h2);
      for (int k = 0; k < 3; k++) begin
        downstream_link_model_i.send_err(err_class_type'(k), e);
        check(32'(e), {29'h0, (i == 2) || (i == 1 && k == 0), 2'(k)});
      end
    end
    bus_access(1'b0, `OFS_BRIDGE_CTRL, 32'h0);
    check(rd, 32'h2);
    stop_test();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
